//--- verilog/rtc_core.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtc_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire rtc_pkg::apb_req_t apb_req,
   output rtc_pkg::apb_rsp_t apb_rsp,
   input wire logic osc_clk_pin,
   input wire logic vdd_fail_pin,
   input wire logic [7:0] vdd_level,
   input wire logic [7:0] bat_level,
   input wire logic [9:0] temp_code,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   output logic scl_rx,
   output logic sda_rx,
   output logic power_on_backup,
   output logic alarm_or_clock_out_pin_o,
   output logic alarm_or_clock_out_pin_oe_n,
   output logic irq
);
   import rtc_pkg::*;

   typedef struct packed {
      time_t tm;
      logic [14:0] presc;
      logic osc_s1;
      logic osc_s2;
      logic osc_prev;
      logic fail_s1;
      logic fail_s2;
      logic backup;
      logic sda_s1;
      logic sda_s2;
      logic scl_s1;
      logic scl_s2;
      logic sda_rx;
      logic scl_rx;
      logic [3:0] fsel;
      alarm_mode_t amode;
      logic dst_en;
      logic dst_active;
      logic [2:0] pf_trip;
      logic [2:0] bat_trip;
      alarm_t alm;
      dst_point_t dst_start;
      dst_point_t dst_end;
      time_t ts_v2b;
      time_t ts_b2v;
      logic [NUM_EV-1:0] status;
      logic [NUM_EV-1:0] ien;
      logic [31:0] rdata;
      logic slverr;
      logic pin_oe_n;
   } state_t;

   state_t q;
   state_t d;
   logic [7:0] sram_mem [SRAM_WORDS];
   logic fout;
   logic osc_rise;
   logic tick;
   logic wr_en;
   logic sram_sel;
   logic alarm_match;
   logic alarm_to_pin;
   logic [NUM_EV-1:0] ev;
   logic [NUM_EV-1:0] clr;
   time_t nt;

   // =====================================================================
   // Calendar arithmetic
   // =====================================================================
   function automatic logic [4:0] days_in_month(input logic [3:0] m, input logic [6:0] y);
      logic [4:0] n;
      n = 5'd31;
      case (m)
         4'd4, 4'd6, 4'd9, 4'd11: n = 5'd30;
         // Every fourth year is leap up to 2099, so 2000 needs no exception
         4'd2: n = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
         default: n = 5'd31;
      endcase
      return n;
   endfunction

   function automatic time_t next_time(input time_t t);
      time_t r;
      r = t;
      if (t.sec != 6'd59) begin
         r.sec = t.sec + 6'd1;
      end else begin
         r.sec = 6'd0;
         if (t.min != 6'd59) begin
            r.min = t.min + 6'd1;
         end else begin
            r.min = 6'd0;
            if (t.hour != 5'd23) begin
               r.hour = t.hour + 5'd1;
            end else begin
               r.hour = 5'd0;
               r.dow = (t.dow == DOW_LAST) ? 3'd0 : t.dow + 3'd1;
               if (t.date < days_in_month(t.month, t.year)) begin
                  r.date = t.date + 5'd1;
               end else begin
                  r.date = 5'd1;
                  if (t.month != 4'd12) begin
                     r.month = t.month + 4'd1;
                  end else begin
                     r.month = 4'd1;
                     r.year = (t.year == YEAR_LAST) ? 7'd0 : t.year + 7'd1;
                  end
               end
            end
         end
      end
      return r;
   endfunction

   function automatic logic dst_hit(input time_t t, input dst_point_t p);
      return (t.month == p.month) && (t.date == p.date) && (t.hour == p.hour) &&
             (t.min == 6'd0) && (t.sec == 6'd0);
   endfunction

   // Trip code n sets the threshold at 32*n on the level scale
   function automatic logic [7:0] trip_level(input logic [2:0] code);
      return {code, 5'h00};
   endfunction

   function automatic logic [31:0] pack_alm(input logic en, input logic [6:0] v);
      return {24'h00_0000, en, v};
   endfunction

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb begin
      d = q;
      ev = '0;
      clr = '0;
      tick = 1'b0;
      nt = q.tm;
      alarm_match = 1'b0;

      // Pins from other domains, two flops before use
      d.osc_s1 = osc_clk_pin;
      d.osc_s2 = q.osc_s1;
      d.osc_prev = q.osc_s2;
      d.fail_s1 = vdd_fail_pin;
      d.fail_s2 = q.fail_s1;
      d.sda_s1 = sda_i;
      d.sda_s2 = q.sda_s1;
      d.scl_s1 = scl_i;
      d.scl_s2 = q.scl_s1;
      osc_rise = q.osc_s2 & ~q.osc_prev;

      // Supply selection and switchover stamps
      d.backup = q.fail_s2;
      if (q.fail_s2 && !q.backup) begin
         d.ts_v2b = q.tm;
         ev[EV_TS_V2B] = 1'b1;
      end
      if (!q.fail_s2 && q.backup) begin
         d.ts_b2v = q.tm;
         ev[EV_TS_B2V] = 1'b1;
      end

      // Bus lines idle high while on backup
      d.sda_rx = q.sda_s2 | q.backup;
      d.scl_rx = q.scl_s2 | q.backup;

      // Seconds prescaler
      if (osc_rise) begin
         if (q.presc == PRESC_LAST) begin
            d.presc = '0;
            tick = 1'b1;
         end else begin
            d.presc = q.presc + 15'd1;
         end
      end

      if (tick) begin
         nt = next_time(q.tm);
         if (q.dst_en && !q.dst_active && dst_hit(nt, q.dst_start) && nt.hour != 5'd23) begin
            nt.hour = nt.hour + 5'd1;
            d.dst_active = 1'b1;
         end else if (q.dst_en && q.dst_active && dst_hit(nt, q.dst_end) && nt.hour != 5'd0) begin
            nt.hour = nt.hour - 5'd1;
            d.dst_active = 1'b0;
         end
         d.tm = nt;
         ev[EV_SECOND] = 1'b1;
         alarm_match = (q.alm.sec_en | q.alm.min_en | q.alm.hour_en | q.alm.date_en |
                        q.alm.month_en) &&
                       (!q.alm.sec_en || nt.sec == q.alm.sec) &&
                       (!q.alm.min_en || nt.min == q.alm.min) &&
                       (!q.alm.hour_en || nt.hour == q.alm.hour) &&
                       (!q.alm.date_en || nt.date == q.alm.date) &&
                       (!q.alm.month_en || nt.month == q.alm.month);
         if (alarm_match && q.amode != ALM_OFF) begin
            ev[EV_ALARM] = 1'b1;
            if (q.amode == ALM_ONCE) begin
               d.amode = ALM_OFF;
            end
         end
      end

      // Supply monitors against chosen thresholds
      if (vdd_level < trip_level(q.pf_trip)) begin
         ev[EV_VDD_LOW] = 1'b1;
      end
      if (bat_level < trip_level(q.bat_trip)) begin
         ev[EV_BAT_LOW] = 1'b1;
      end

      // APB setup phase: precompute answer so prdata comes from a flop
      if (apb_req.psel && !apb_req.penable) begin
         d.rdata = 32'h0000_0000;
         d.slverr = 1'b0;
         if (q.backup) begin
            d.slverr = 1'b1;
         end else if (apb_req.paddr[11:9] == SRAM_BASE[11:9]) begin
            if (!apb_req.pwrite) begin
               d.rdata = {24'h00_0000, sram_mem[apb_req.paddr[8:2]]};
            end
         end else if (apb_req.paddr[1:0] != 2'b00) begin
            d.slverr = 1'b1;
         end else begin
            case (apb_req.paddr)
               OFF_SEC: d.rdata = {26'h000_0000, q.tm.sec};
               OFF_MIN: d.rdata = {26'h000_0000, q.tm.min};
               OFF_HOUR: d.rdata = {27'h000_0000, q.tm.hour};
               OFF_DATE: d.rdata = {27'h000_0000, q.tm.date};
               OFF_MONTH: d.rdata = {28'h000_0000, q.tm.month};
               OFF_YEAR: d.rdata = {25'h000_0000, q.tm.year};
               OFF_DOW: d.rdata = {29'h0000_0000, q.tm.dow};
               OFF_CTRL: d.rdata = {19'h0_0000, q.bat_trip, q.pf_trip, q.dst_en, q.amode, q.fsel};
               OFF_STATUS: d.rdata = {23'h00_0000, q.backup, 2'b00, q.status};
               OFF_CLEAR: d.rdata = 32'h0000_0000;
               OFF_IEN: d.rdata = {26'h000_0000, q.ien};
               OFF_ALM_SEC: d.rdata = pack_alm(q.alm.sec_en, {1'b0, q.alm.sec});
               OFF_ALM_MIN: d.rdata = pack_alm(q.alm.min_en, {1'b0, q.alm.min});
               OFF_ALM_HOUR: d.rdata = pack_alm(q.alm.hour_en, {2'b00, q.alm.hour});
               OFF_ALM_DATE: d.rdata = pack_alm(q.alm.date_en, {2'b00, q.alm.date});
               OFF_ALM_MONTH: d.rdata = pack_alm(q.alm.month_en, {3'b000, q.alm.month});
               OFF_TEMP: d.rdata = {22'h00_0000, temp_code};
               OFF_DST_START: d.rdata = {11'h000, q.dst_start.hour, 3'b000,
                                         q.dst_start.date, 4'h0, q.dst_start.month};
               OFF_DST_END: d.rdata = {11'h000, q.dst_end.hour, 3'b000,
                                       q.dst_end.date, 4'h0, q.dst_end.month};
               OFF_TS_V2B_LO: d.rdata = {11'h000, q.ts_v2b.hour, 2'b00, q.ts_v2b.min,
                                         2'b00, q.ts_v2b.sec};
               OFF_TS_V2B_HI: d.rdata = {9'h000, q.ts_v2b.year, 4'h0, q.ts_v2b.month,
                                         3'b000, q.ts_v2b.date};
               OFF_TS_B2V_LO: d.rdata = {11'h000, q.ts_b2v.hour, 2'b00, q.ts_b2v.min,
                                         2'b00, q.ts_b2v.sec};
               OFF_TS_B2V_HI: d.rdata = {9'h000, q.ts_b2v.year, 4'h0, q.ts_b2v.month,
                                         3'b000, q.ts_b2v.date};
               OFF_INFO: d.rdata = {25'h000_0000, USER_TARGET_ADDR};
               default: d.slverr = 1'b1;
            endcase
         end
      end

      // APB access phase: writes land here, after the tick so they win
      wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && !q.backup;
      sram_sel = apb_req.paddr[11:9] == SRAM_BASE[11:9];
      if (wr_en && !sram_sel) begin
         case (apb_req.paddr)
            OFF_SEC: begin
               d.tm.sec = apb_req.pwdata[5:0];
               d.presc = '0;
            end
            OFF_MIN: d.tm.min = apb_req.pwdata[5:0];
            OFF_HOUR: d.tm.hour = apb_req.pwdata[4:0];
            OFF_DATE: d.tm.date = apb_req.pwdata[4:0];
            OFF_MONTH: d.tm.month = apb_req.pwdata[3:0];
            OFF_YEAR: d.tm.year = apb_req.pwdata[6:0];
            OFF_DOW: d.tm.dow = apb_req.pwdata[2:0];
            OFF_CTRL: begin
               d.fsel = apb_req.pwdata[CTRL_FSEL_LSB +: 4];
               d.amode = alarm_mode_t'(apb_req.pwdata[CTRL_AMODE_LSB +: 2]);
               d.dst_en = apb_req.pwdata[CTRL_DST_EN_BIT];
               d.pf_trip = apb_req.pwdata[CTRL_PF_TRIP_LSB +: 3];
               d.bat_trip = apb_req.pwdata[CTRL_BAT_TRIP_LSB +: 3];
            end
            OFF_CLEAR: clr = apb_req.pwdata[NUM_EV-1:0];
            OFF_IEN: d.ien = apb_req.pwdata[NUM_EV-1:0];
            OFF_ALM_SEC: {d.alm.sec_en, d.alm.sec} = {apb_req.pwdata[ALM_EN_BIT],
                                                      apb_req.pwdata[5:0]};
            OFF_ALM_MIN: {d.alm.min_en, d.alm.min} = {apb_req.pwdata[ALM_EN_BIT],
                                                      apb_req.pwdata[5:0]};
            OFF_ALM_HOUR: {d.alm.hour_en, d.alm.hour} = {apb_req.pwdata[ALM_EN_BIT],
                                                         apb_req.pwdata[4:0]};
            OFF_ALM_DATE: {d.alm.date_en, d.alm.date} = {apb_req.pwdata[ALM_EN_BIT],
                                                         apb_req.pwdata[4:0]};
            OFF_ALM_MONTH: {d.alm.month_en, d.alm.month} = {apb_req.pwdata[ALM_EN_BIT],
                                                            apb_req.pwdata[3:0]};
            OFF_DST_START: d.dst_start = {apb_req.pwdata[3:0],
                                          apb_req.pwdata[DST_DATE_LSB +: 5],
                                          apb_req.pwdata[DST_HOUR_LSB +: 5]};
            OFF_DST_END: d.dst_end = {apb_req.pwdata[3:0],
                                      apb_req.pwdata[DST_DATE_LSB +: 5],
                                      apb_req.pwdata[DST_HOUR_LSB +: 5]};
            default: d.dst_end = q.dst_end;
         endcase
      end

      // Sticky events: a new event beats a clear in the same cycle
      d.status = (q.status & ~clr) | ev;

      // Polled mode keeps alarms off the pin and the interrupt line
      alarm_to_pin = q.status[EV_ALARM] && q.ien[EV_ALARM] && q.amode != ALM_POLLED;
      if (q.fsel == FSEL_IRQ) begin
         d.pin_oe_n = !alarm_to_pin;
      end else begin
         d.pin_oe_n = fout;
      end
   end

   // =====================================================================
   // State registers
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.tm.date <= DATE_RST;
         q.tm.month <= MONTH_RST;
         q.tm.year <= YEAR_RST;
         q.tm.dow <= DOW_RST;
         q.fsel <= FSEL_RST;
         q.amode <= ALM_OFF;
         q.pf_trip <= TRIP_RST;
         q.bat_trip <= TRIP_RST;
         q.sda_rx <= 1'b1;
         q.scl_rx <= 1'b1;
         q.pin_oe_n <= 1'b1;
      end else if (ce) begin
         q <= d;
      end
   end

   // Storage keeps no reset: its contents must outlive supply changes
   always_ff @(posedge pclk) begin
      if (ce && wr_en && sram_sel) begin
         sram_mem[apb_req.paddr[8:2]] <= apb_req.pwdata[7:0];
      end
   end

   rtc_fout_gen u_fout (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .osc_rise(osc_rise),
      .osc_level(q.osc_s2),
      .fsel(q.fsel),
      .fout_q(fout)
   );

   // =====================================================================
   // Outputs
   // =====================================================================
   assign apb_rsp.prdata = q.rdata;
   assign apb_rsp.pready = ce;
   assign apb_rsp.pslverr = q.slverr;
   assign irq = |(q.status & q.ien & {{(NUM_EV-1){1'b1}}, q.amode != ALM_POLLED});
   assign power_on_backup = q.backup;
   assign scl_rx = q.scl_rx;
   assign sda_rx = q.sda_rx;
   // No transmit engine here; the data line is never driven, its output enable stays off
   assign sda_o = 1'b0;
   assign sda_oe_n = 1'b1;
   assign alarm_or_clock_out_pin_o = 1'b0;
   assign alarm_or_clock_out_pin_oe_n = q.pin_oe_n;
endmodule // rtc_core
`default_nettype wire

//--- verilog/rtc_pkg.sv
package rtc_pkg;

   // =====================================================================
   // Bus and memory geometry
   // =====================================================================
   localparam int ADDR_W = 12;
   localparam int SRAM_WORDS = 128;
   localparam logic [11:0] SRAM_BASE = 12'h200;
   // Serial-bus target address of the user storage, reported read-only
   localparam logic [6:0] USER_TARGET_ADDR = 7'h57;

   // =====================================================================
   // Register byte offsets
   // =====================================================================
   localparam logic [11:0] OFF_SEC = 12'h000;
   localparam logic [11:0] OFF_MIN = 12'h004;
   localparam logic [11:0] OFF_HOUR = 12'h008;
   localparam logic [11:0] OFF_DATE = 12'h00c;
   localparam logic [11:0] OFF_MONTH = 12'h010;
   localparam logic [11:0] OFF_YEAR = 12'h014;
   localparam logic [11:0] OFF_DOW = 12'h018;
   localparam logic [11:0] OFF_CTRL = 12'h01c;
   localparam logic [11:0] OFF_STATUS = 12'h020;
   localparam logic [11:0] OFF_CLEAR = 12'h024;
   localparam logic [11:0] OFF_IEN = 12'h028;
   localparam logic [11:0] OFF_ALM_SEC = 12'h02c;
   localparam logic [11:0] OFF_ALM_MIN = 12'h030;
   localparam logic [11:0] OFF_ALM_HOUR = 12'h034;
   localparam logic [11:0] OFF_ALM_DATE = 12'h038;
   localparam logic [11:0] OFF_ALM_MONTH = 12'h03c;
   localparam logic [11:0] OFF_TEMP = 12'h040;
   localparam logic [11:0] OFF_DST_START = 12'h044;
   localparam logic [11:0] OFF_DST_END = 12'h048;
   localparam logic [11:0] OFF_TS_V2B_LO = 12'h04c;
   localparam logic [11:0] OFF_TS_V2B_HI = 12'h050;
   localparam logic [11:0] OFF_TS_B2V_LO = 12'h054;
   localparam logic [11:0] OFF_TS_B2V_HI = 12'h058;
   localparam logic [11:0] OFF_INFO = 12'h05c;

   // =====================================================================
   // Field positions
   // =====================================================================
   localparam int CTRL_FSEL_LSB = 0;
   localparam int CTRL_AMODE_LSB = 4;
   localparam int CTRL_DST_EN_BIT = 6;
   localparam int CTRL_PF_TRIP_LSB = 7;
   localparam int CTRL_BAT_TRIP_LSB = 10;
   localparam int ALM_EN_BIT = 7;
   localparam int STATUS_BACKUP_BIT = 8;
   localparam int DST_DATE_LSB = 8;
   localparam int DST_HOUR_LSB = 16;

   localparam int NUM_EV = 6;
   localparam int EV_ALARM = 0;
   localparam int EV_TS_V2B = 1;
   localparam int EV_TS_B2V = 2;
   localparam int EV_VDD_LOW = 3;
   localparam int EV_BAT_LOW = 4;
   localparam int EV_SECOND = 5;

   // =====================================================================
   // Counts and reset values
   // =====================================================================
   localparam logic [14:0] PRESC_LAST = 15'h7fff;
   localparam logic [3:0] FSEL_IRQ = 4'h0;
   localparam logic [3:0] FSEL_OSC = 4'h1;
   localparam logic [3:0] FSEL_RST = 4'h1;
   localparam logic [2:0] TRIP_RST = 3'h0;
   localparam logic [4:0] DATE_RST = 5'h01;
   localparam logic [3:0] MONTH_RST = 4'h1;
   localparam logic [6:0] YEAR_RST = 7'h00;
   localparam logic [2:0] DOW_RST = 3'h6;
   localparam logic [6:0] YEAR_LAST = 7'h63;
   localparam logic [2:0] DOW_LAST = 3'h6;

   // =====================================================================
   // Types
   // =====================================================================
   typedef enum logic [1:0] {ALM_OFF, ALM_ONCE, ALM_PERIODIC, ALM_POLLED} alarm_mode_t;

   typedef struct packed {
      logic [6:0] year;
      logic [3:0] month;
      logic [4:0] date;
      logic [2:0] dow;
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
   } time_t;

   typedef struct packed {
      logic sec_en;
      logic [5:0] sec;
      logic min_en;
      logic [5:0] min;
      logic hour_en;
      logic [4:0] hour;
      logic date_en;
      logic [4:0] date;
      logic month_en;
      logic [3:0] month;
   } alarm_t;

   typedef struct packed {
      logic [3:0] month;
      logic [4:0] date;
      logic [4:0] hour;
   } dst_point_t;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage

//--- verilog/rtc_fout_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_fout_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic osc_rise,
   input wire logic osc_level,
   input wire logic [3:0] fsel,
   output logic fout_q
);
   import rtc_pkg::*;

   logic [13:0] div_q;

   // =====================================================================
   // Binary divider of the oscillator, one tap for each of the rate selects 2 to 15
   // =====================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 14'h0000;
         fout_q <= 1'b1;
      end else if (ce) begin
         if (osc_rise) begin
            div_q <= div_q + 14'h0001;
         end
         if (fsel == FSEL_OSC) begin
            fout_q <= osc_level;
         end else if (fsel == FSEL_IRQ) begin
            fout_q <= 1'b1;
         end else begin
            fout_q <= div_q[fsel - 4'h2];
         end
      end
   end
endmodule // rtc_fout_gen
`default_nettype wire

//--- sim/rtc_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_core_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire rtc_pkg::apb_req_t apb_req,
   input wire rtc_pkg::apb_rsp_t apb_rsp,
   input wire logic osc_clk_pin,
   input wire logic vdd_fail_pin,
   input wire logic sda_i,
   input wire logic sda_oe_n,
   input wire logic scl_rx,
   input wire logic sda_rx,
   input wire logic power_on_backup,
   input wire logic alarm_or_clock_out_pin_o,
   input wire logic alarm_or_clock_out_pin_oe_n
);
   import rtc_pkg::*;
   // ==========
   // Helpers
   logic wrote_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wrote_q <= 1'b0;
      else if (apb_req.psel && apb_req.penable && apb_req.pwrite) wrote_q <= 1'b1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; apb_req.psel && !apb_req.penable; endsequence
   sequence access_s; apb_req.psel && apb_req.penable && apb_rsp.pready; endsequence
   // ==========
   // Properties
   chk_sda_released: assert property (sda_oe_n)
      else $error("sda driven");
   chk_pin_no_high: assert property (alarm_or_clock_out_pin_o == 1'b0)
      else $error("pin driven high");
   chk_backup_gates: assert property ($past(power_on_backup) && power_on_backup |-> scl_rx && sda_rx)
      else $error("serial pins not gated");
   chk_sda_follows: assert property ((!power_on_backup && $stable(sda_i))[*5] |-> sda_rx == sda_i)
      else $error("sda input gated");
   chk_backup_error: assert property ((power_on_backup and setup_s) ##1 (power_on_backup and access_s)
      |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
      else $error("bus served on backup");
   chk_enter_backup: assert property (vdd_fail_pin[*4] |-> power_on_backup)
      else $error("no switch to backup");
   chk_leave_backup: assert property ((!vdd_fail_pin)[*4] |-> !power_on_backup)
      else $error("no return to main");
   chk_default_osc: assert property ((!wrote_q && $stable(osc_clk_pin))[*6]
      |-> alarm_or_clock_out_pin_oe_n == osc_clk_pin)
      else $error("pin not at oscillator");
endmodule // rtc_core_checker
bind rtc_core rtc_core_checker u_chk (.pclk, .presetn, .apb_req, .apb_rsp, .osc_clk_pin,
   .vdd_fail_pin, .sda_i, .sda_oe_n, .scl_rx, .sda_rx, .power_on_backup,
   .alarm_or_clock_out_pin_o, .alarm_or_clock_out_pin_oe_n);
`default_nettype wire

//--- sim/rtc_serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_host (
   input wire logic pclk,
   input wire logic run,
   output logic scl,
   output logic sda
);
   logic [5:0] cnt_q = 6'h00;
   logic [7:0] pat_q = 8'ha5;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Half period of 64 cycles keeps the clock near 390 kHz
   always @(posedge pclk) begin
      cnt_q <= cnt_q + 6'h01;
      if (!run) begin
         scl <= 1'b1;
         sda <= 1'b1;
      end else if (cnt_q == 6'h3f) scl <= ~scl;
      else if (cnt_q == 6'h20 && !scl) begin
         sda <= pat_q[7];
         pat_q <= {pat_q[6:0], ~pat_q[7]};
      end
   end
endmodule // rtc_serial_host
`default_nettype wire

//--- sim/rtc_calendar_alarm_freq_out_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module rtc_calendar_alarm_freq_out_tb_top;
   import rtc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic osc = 1'b0;
   logic vfail = 1'b0;
   logic [7:0] vlev = 8'hff;
   logic [9:0] temp = 10'h000;
   logic scl, sda, er, pin_oe_n, irq, backup, scl_rx, bk1;
   logic [31:0] rd, a, d;
   logic [31:0] seed = 32'h0000_cdc5;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int p = 0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic [11:0] ra [9] = '{OFF_SEC, OFF_MIN, OFF_HOUR, OFF_DATE, OFF_MONTH, OFF_YEAR, OFF_DOW,
      OFF_CTRL, OFF_INFO};
   logic [31:0] rv [9] = '{0, 0, 0, 1, 1, 0, 6, 1, 32'h0000_0057};
   rtc_core DUT (.pclk, .presetn, .ce(1'b1), .apb_req(req), .apb_rsp(rsp), .osc_clk_pin(osc),
      .vdd_fail_pin(vfail), .vdd_level(vlev), .bat_level(8'hff), .temp_code(temp), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe_n(), .scl_rx, .sda_rx(), .power_on_backup(backup),
      .alarm_or_clock_out_pin_o(), .alarm_or_clock_out_pin_oe_n(pin_oe_n), .irq);
   rtc_serial_host host (.pclk, .run(1'b1), .scl, .sda);
   initial forever #10 pclk = ~pclk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic finish_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] wd);
      @(posedge pclk);
      req <= '{paddr: ad, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // Slow oscillator stand-in, plus the hang limit
   always @(posedge pclk) begin
      cyc++;
      if (cyc % 10 == 0) osc <= ~osc;
      if (cyc > 20000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) begin
         apb(ra[i], 1'b0, 0);
         `CHK("reset", rv[i], rd)
      end
      apb(12'h100, 1'b0, 0);
      `CHK("unmapped", 33'h1_0000_0000, {er, rd})
      $display("reset and map done");
      repeat (8) begin
         a = rnd();
         d = rnd();
         temp <= d[9:0];
         apb(SRAM_BASE + {a[6:0], 2'b00}, 1'b1, d);
         apb(SRAM_BASE + {a[6:0], 2'b00}, 1'b0, 0);
         `CHK("storage", {24'h00_0000, d[7:0]}, rd)
         apb(OFF_TEMP, 1'b0, 0);
         `CHK("temp", {22'h00_0000, d[9:0]}, rd)
      end
      for (int i = 0; i < 64; i++) begin
         apb(OFF_CTRL, 1'b1, 32'(i));
         apb(OFF_CTRL, 1'b0, 0);
         `CHK("ctrl", 32'(i), rd)
      end
      $display("storage and control done");
      // Oscillator period is 20 cycles here, so rate n gives 20 * 2^(n-1)
      for (int k = 1; k < 5; k++) begin
         apb(OFF_CTRL, 1'b1, 32'(k));
         repeat (3) @(posedge pin_oe_n);
         p = cyc;
         @(posedge pin_oe_n);
         `CHK("fout period", 20 << (k - 1), cyc - p)
      end
      $display("frequency out done");
      // Interrupt mode with trip code 3: threshold 96
      apb(OFF_CTRL, 1'b1, 32'h0000_0180);
      vlev <= 8'h32;
      repeat (4) @(posedge pclk);
      apb(OFF_STATUS, 1'b0, 0);
      `CHK("status low", 32'h0000_0008, rd)
      `CHK("irq masked", 1'b0, irq)
      apb(OFF_IEN, 1'b1, 32'h0000_0008);
      @(posedge pclk);
      `CHK("irq", 1'b1, irq)
      `CHK("pin no alarm", 1'b1, pin_oe_n)
      vlev <= 8'hc8;
      apb(OFF_CLEAR, 1'b1, 32'h0000_0008);
      @(posedge pclk);
      `CHK("irq clear", 1'b0, irq)
      $display("monitor done");
      vfail <= 1'b1;
      bk1 = 1'b0;
      // Gating lags the supply flag by one cycle, so check from its second cycle
      repeat (130) begin
         @(posedge pclk);
         if (backup === 1'b1 && bk1 === 1'b1) `CHK("scl gated", 1'b1, scl_rx)
         bk1 = backup;
      end
      apb(OFF_SEC, 1'b0, 0);
      `CHK("backup err", 1'b1, er)
      vfail <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(OFF_STATUS, 1'b0, 0);
      `CHK("stamps", 32'h0000_0006, rd)
      apb(OFF_TS_V2B_HI, 1'b0, 0);
      `CHK("stamp date", 32'h0000_0101, rd)
      $display("backup done");
      finish_test();
   end
endmodule // rtc_calendar_alarm_freq_out_tb_top
`default_nettype wire
